// *** design/lsd_pkg.sv ***
// Package with the constants, register map and level codes of the segment LCD driver.
package lsd_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DIV_W = 16;
	localparam int NUM_COM = 8;
	localparam int NUM_SEG = 24;
	localparam int SEG_E_MAX = 20;
	localparam int MEM_DEPTH = 20;
	localparam int LV_W = 3;
	// Own registers sit at byte addresses; display memory is index times four.
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_DIV = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] MEM_FIRST_IDX = 8'h20;
	localparam logic [ADDR_W-1:0] MEM_LAST_Q_IDX = 8'h2B;
	localparam logic [ADDR_W-1:0] MEM_LAST_E_IDX = 8'h33;
	localparam int CTRL_LADDER = 0;
	localparam int CTRL_BRIT_LO = 1;
	localparam int CTRL_BRIT_HI = 3;
	localparam int CTRL_MODE_LO = 4;
	localparam int CTRL_MODE_HI = 5;
	localparam int CTRL_SRC = 6;
	localparam int CTRL_W = 7;
	localparam int STAT_POL = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0100;
	localparam logic [1:0] MODE_STATIC = 2'h0;
	localparam logic [1:0] MODE_Q_HALF = 2'h1;
	localparam logic [1:0] MODE_Q_THIRD = 2'h2;
	localparam logic [1:0] MODE_E_QUARTER = 2'h3;
	localparam logic [2:0] LAST_COM_STATIC = 3'h0;
	localparam logic [2:0] LAST_COM_Q = 3'h3;
	localparam logic [2:0] LAST_COM_E = 3'h7;
	localparam int NIB_W = 4;
	// Level codes in ascending voltage; mirroring a code is LV_FULL minus it.
	localparam logic [LV_W-1:0] LV_ZERO = 3'h0;
	localparam logic [LV_W-1:0] LV_QUARTER = 3'h1;
	localparam logic [LV_W-1:0] LV_THIRD = 3'h2;
	localparam logic [LV_W-1:0] LV_HALF = 3'h3;
	localparam logic [LV_W-1:0] LV_TWO_THIRD = 3'h4;
	localparam logic [LV_W-1:0] LV_THREE_QTR = 3'h5;
	localparam logic [LV_W-1:0] LV_FULL = 3'h6;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage : lsd_pkg

// *** design/lsd_scan_if.sv ***
// Interface carrying scan timing between the register side and the scan generator.
`timescale 1ns/10ps
interface lsd_scan_if;
	import lsd_pkg::*;
	logic src_sel;
	logic slow_rise;
	logic [DIV_W-1:0] reload;
	logic [2:0] last_com;
	logic scan_tick;
	logic [2:0] com_idx;
	logic frame_pol;
	modport ctl (output src_sel, output slow_rise, output reload, output last_com,
		input scan_tick, input com_idx, input frame_pol);
	modport gen (input src_sel, input slow_rise, input reload, input last_com,
		output scan_tick, output com_idx, output frame_pol);
endinterface : lsd_scan_if

// *** design/lsd_scan.sv ***
// Scan generator: timer-2 style divider, common sequencing and frame polarity.
`timescale 1ns/10ps
module lsd_scan
	import lsd_pkg::*;
(
	input wire logic sys_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	lsd_scan_if.gen sif // Scan timing carrier.
);
	logic [DIV_W-1:0] div_cnt_r;
	logic src_tick;
	logic div_wrap;

	// The timer-2 path counts either every CPU clock or each slow clock rise.
	assign src_tick = sif.src_sel ? sif.slow_rise : 1'b1;
	assign div_wrap = src_tick && (div_cnt_r >= sif.reload);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_cnt_r <= '0;
		end else if (div_wrap) begin
			div_cnt_r <= '0;
		end else if (src_tick) begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sif.scan_tick <= 1'b0;
		end else begin
			sif.scan_tick <= div_wrap;
		end
	end

	// A shortened common count after a mode change simply wraps at the next slot.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sif.com_idx <= '0;
			sif.frame_pol <= 1'b0;
		end else if (div_wrap) begin
			if (sif.com_idx >= sif.last_com) begin
				sif.com_idx <= '0;
				sif.frame_pol <= ~sif.frame_pol;
			end else begin
				sif.com_idx <= sif.com_idx + 1'b1;
			end
		end
	end
endmodule : lsd_scan

// *** design/lsd_top.sv ***
// Segment LCD driver top: Avalon-MM registers, display memory and level generation.
`timescale 1ns/10ps
module lsd_top
	import lsd_pkg::*;
(
	input wire logic sys_clk, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [ADDR_W-1:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [DATA_W-1:0] avs_writedata, // Write data.
	input wire logic [3:0] avs_byteenable, // Byte lanes of a write.
	output logic [DATA_W-1:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall, high until the answer cycle.
	input wire logic slow_clk_in, // Slow clock pin, sampled.
	output logic ladder_enable, // Resistor ladder on.
	output logic [2:0] brightness_select, // Top voltage selection.
	output logic lcd_scan_clock, // One pulse per common slot.
	output logic [NUM_COM*LV_W-1:0] com_level, // Level code per common line.
	output logic [NUM_SEG*LV_W-1:0] seg_level // Level code per segment line.
);
	lsd_scan_if sif ();

	logic [CTRL_W-1:0] ctrl_r;
	logic [DIV_W-1:0] div_r;
	logic [7:0] mem_r [MEM_DEPTH];
	logic slow_s1_r;
	logic slow_s2_r;
	logic slow_s3_r;
	logic access;
	logic wr_fire;
	logic [ADDR_W-1:0] idx;
	logic [1:0] mode;
	logic [NUM_COM*LV_W-1:0] com_lv_nxt;
	logic [NUM_SEG*LV_W-1:0] seg_lv_nxt;

	assign mode = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];
	// Display memory index is the word address.
	assign idx = {2'b00, avs_address[ADDR_W-1:2]};
	assign access = avs_read || avs_write;
	assign wr_fire = avs_write && !avs_waitrequest;

	// Memory reach depends on duty; locations beyond it are unmapped.
	function automatic logic mem_hit(input logic [ADDR_W-1:0] i, input logic [1:0] m);
		logic [ADDR_W-1:0] last;
		last = (m == MODE_E_QUARTER) ? MEM_LAST_E_IDX : MEM_LAST_Q_IDX;
		mem_hit = (i >= MEM_FIRST_IDX) && (i <= last);
	endfunction : mem_hit

	function automatic logic [4:0] mem_slot(input logic [ADDR_W-1:0] i);
		logic [ADDR_W-1:0] d;
		d = i - MEM_FIRST_IDX;
		mem_slot = d[4:0];
	endfunction : mem_slot

	function automatic logic [LV_W-1:0] mirror(input logic [LV_W-1:0] lv, input logic pol);
		mirror = pol ? LV_FULL - lv : lv;
	endfunction : mirror

	// Unselected common level sets the bias of each configuration.
	function automatic logic [LV_W-1:0] com_unsel(input logic [1:0] m);
		case (m)
			MODE_Q_HALF: com_unsel = LV_HALF;
			MODE_Q_THIRD: com_unsel = LV_THIRD;
			MODE_E_QUARTER: com_unsel = LV_QUARTER;
			default: com_unsel = LV_ZERO;
		endcase
	endfunction : com_unsel

	function automatic logic [LV_W-1:0] seg_off(input logic [1:0] m);
		case (m)
			MODE_Q_THIRD: seg_off = LV_TWO_THIRD;
			MODE_E_QUARTER: seg_off = LV_HALF;
			default: seg_off = LV_FULL;
		endcase
	endfunction : seg_off

	function automatic logic [2:0] last_com_of(input logic [1:0] m);
		case (m)
			MODE_STATIC: last_com_of = LAST_COM_STATIC;
			MODE_E_QUARTER: last_com_of = LAST_COM_E;
			default: last_com_of = LAST_COM_Q;
		endcase
	endfunction : last_com_of

	// Slow clock pin passes two flops before the edge detector looks at it.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slow_s1_r <= 1'b0;
			slow_s2_r <= 1'b0;
			slow_s3_r <= 1'b0;
		end else begin
			slow_s1_r <= slow_clk_in;
			slow_s2_r <= slow_s1_r;
			slow_s3_r <= slow_s2_r;
		end
	end

	assign sif.slow_rise = slow_s2_r && !slow_s3_r;
	assign sif.src_sel = ctrl_r[CTRL_SRC];
	assign sif.reload = div_r;
	assign sif.last_com = last_com_of(mode);

	lsd_scan u_scan (
		.sys_clk (sys_clk),
		.rst (rst),
		.sif (sif)
	);

	// Every access waits one cycle; the fixed answer keeps the slave simple.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (access && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			avs_readdata <= RD_ZERO;
		end else if (avs_read && avs_waitrequest) begin
			if (avs_address == REG_CTRL) begin
				avs_readdata <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
			end else if (avs_address == REG_DIV) begin
				avs_readdata <= {{(DATA_W-DIV_W){1'b0}}, div_r};
			end else if (avs_address == REG_STAT) begin
				avs_readdata <= {{(DATA_W-STAT_POL-1){1'b0}}, sif.frame_pol, sif.com_idx};
			end else if (avs_address[1:0] == 2'b00 && mem_hit(idx, mode)) begin
				avs_readdata <= {{(DATA_W-8){1'b0}}, mem_r[mem_slot(idx)]};
			end else begin
				avs_readdata <= RD_ZERO;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_fire && avs_address == REG_CTRL && avs_byteenable[0]) begin
			ctrl_r <= avs_writedata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			div_r <= DIV_RST;
		end else if (wr_fire && avs_address == REG_DIV) begin
			if (avs_byteenable[0]) begin
				div_r[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				div_r[15:8] <= avs_writedata[15:8];
			end
		end
	end

	// Display memory powers up blank so the panel shows nothing until written.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_r[i] <= 8'h00;
			end
		end else if (wr_fire && avs_byteenable[0] && avs_address[1:0] == 2'b00
				&& mem_hit(idx, mode)) begin
			mem_r[mem_slot(idx)] <= avs_writedata[7:0];
		end
	end

	// Common levels: the selected line swings to a rail, the other used lines sit at bias, lines past the last common at zero.
	generate
		for (genvar c = 0; c < NUM_COM; c++) begin : g_com
			always_comb begin
				if (!ctrl_r[CTRL_LADDER]) begin
					com_lv_nxt[c*LV_W +: LV_W] = LV_ZERO;
				end else if (3'(c) > last_com_of(mode)) begin
					com_lv_nxt[c*LV_W +: LV_W] = LV_ZERO;
				end else if (3'(c) == sif.com_idx) begin
					com_lv_nxt[c*LV_W +: LV_W] = mirror(LV_FULL, sif.frame_pol);
				end else begin
					com_lv_nxt[c*LV_W +: LV_W] = mirror(com_unsel(mode), sif.frame_pol);
				end
			end
		end
	endgenerate

	// Segment data: eighth duty reads one byte per segment for segments below 20 (the rest read zero), static reads bit 0 for even segments only, else a nibble.
	generate
		for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
			logic on;
			logic [7:0] byte_q;
			logic [7:0] byte_e;
			if (s / 2 < MEM_DEPTH) begin : g_q
				assign byte_q = mem_r[s/2];
			end else begin : g_qz
				assign byte_q = 8'h00;
			end
			if (s < SEG_E_MAX) begin : g_e
				assign byte_e = mem_r[s];
			end else begin : g_ez
				assign byte_e = 8'h00;
			end
			always_comb begin
				case (mode)
					MODE_E_QUARTER: on = byte_e[sif.com_idx];
					MODE_STATIC: on = (s % 2 == 0) && byte_q[(s%2)*NIB_W];
					default: on = byte_q[(s%2)*NIB_W + int'(sif.com_idx[1:0])];
				endcase
			end
			always_comb begin
				if (!ctrl_r[CTRL_LADDER]) begin
					seg_lv_nxt[s*LV_W +: LV_W] = LV_ZERO;
				end else if (on) begin
					seg_lv_nxt[s*LV_W +: LV_W] = mirror(LV_ZERO, sif.frame_pol);
				end else begin
					seg_lv_nxt[s*LV_W +: LV_W] = mirror(seg_off(mode), sif.frame_pol);
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			com_level <= '0;
			seg_level <= '0;
		end else begin
			com_level <= com_lv_nxt;
			seg_level <= seg_lv_nxt;
		end
	end

	// The ladder and brightness drive analog switches, so they come from flops.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ladder_enable <= 1'b0;
			brightness_select <= 3'h0;
			lcd_scan_clock <= 1'b0;
		end else begin
			ladder_enable <= ctrl_r[CTRL_LADDER];
			brightness_select <= ctrl_r[CTRL_BRIT_HI:CTRL_BRIT_LO];
			lcd_scan_clock <= sif.scan_tick;
		end
	end
endmodule : lsd_top

// *** bench/lsd_glass.sv ***
// Passive glass model that sums the drive across the pixel at common 0 and segment 0.
`timescale 1ns/10ps
module lsd_glass
	import lsd_pkg::*;
(
	input wire logic sys_clk, // Clock.
	input wire logic [NUM_COM*LV_W-1:0] com_level, // Commons.
	input wire logic [NUM_SEG*LV_W-1:0] seg_level, // Segments.
	input wire logic lcd_scan_clock, // Slot pulse.
	output int dc // Running pixel sum.
);
	int sum_r = 0;
	// One sample per slot; a drive free of bias sums to zero over two frames.
	always @(posedge sys_clk) begin
		if (lcd_scan_clock === 1'b1)
			sum_r <= sum_r + int'(com_level[2:0]) - int'(seg_level[2:0]);
	end
	assign dc = sum_r;
endmodule : lsd_glass

// *** bench/lsd_top_checker.sv ***
// Port checker for the segment LCD driver.
`timescale 1ns/10ps
module lsd_top_checker
	import lsd_pkg::*;
(
	input wire logic sys_clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic [ADDR_W-1:0] avs_address, // Address.
	input wire logic avs_write, // Write.
	input wire logic [DATA_W-1:0] avs_writedata, // Data.
	input wire logic [3:0] avs_byteenable, // Lanes.
	input wire logic avs_waitrequest, // Stall.
	input wire logic ladder_enable, // Ladder.
	input wire logic [2:0] brightness_select, // Brightness.
	input wire logic lcd_scan_clock, // Slot pulse.
	input wire logic [NUM_COM*LV_W-1:0] com_level, // Commons.
	input wire logic [NUM_SEG*LV_W-1:0] seg_level // Segments.
);
	logic [1:0] mode_r;
	logic [3:0] quiet_r;
	logic bad_code;
	wire wr_ok = avs_write && !avs_waitrequest;
	wire ctrl_wr = wr_ok && avs_address == REG_CTRL && avs_byteenable[0];
	wire [95:0] all_lv = {seg_level, com_level};
	always_ff @(posedge sys_clk) begin
		if (rst)
			mode_r <= MODE_STATIC;
		else if (ctrl_wr)
			mode_r <= avs_writedata[5:4];
	end
	// Any write may move the levels, so this counts cycles since the last one.
	always_ff @(posedge sys_clk) begin
		if (rst || wr_ok)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	always_comb begin
		bad_code = 1'b0;
		for (int i = 0; i < 32; i++)
			bad_code |= all_lv[i*3 +: 3] == 3'h7;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	code_range_a: assert property (!bad_code) else $error("bad level code");
	ladder_off_a: assert property (!ladder_enable && $past(!ladder_enable) |->
		com_level == 0 && seg_level == 0) else $error("levels with ladder off");
	ladder_copy_a: assert property (ctrl_wr |-> ##2 ladder_enable == $past(avs_writedata[0], 2))
		else $error("ladder bit lost");
	bright_copy_a: assert property (ctrl_wr |-> ##2 brightness_select == $past(avs_writedata[3:1], 2))
		else $error("brightness lost");
	static_com_a: assert property (mode_r == MODE_STATIC && quiet_r > 4 |-> com_level[23:3] == 0)
		else $error("static common");
	quarter_com_a: assert property (mode_r inside {2'h1, 2'h2} && quiet_r > 4 |-> com_level[23:12] == 0)
		else $error("quarter common");
	// The levels and the slot pulse are loaded at the same edge, so a change is seen only with the pulse up.
	slot_hold_a: assert property (quiet_r > 4 && !lcd_scan_clock |->
		$stable(com_level) && $stable(seg_level)) else $error("levels moved in slot");
	pulse_one_a: assert property (lcd_scan_clock |=> !lcd_scan_clock) else $error("long pulse");
	cover property (lcd_scan_clock && mode_r == MODE_E_QUARTER);
	cover property (lcd_scan_clock && mode_r == MODE_STATIC && ladder_enable);
	cover property (ctrl_wr);
endmodule : lsd_top_checker
bind lsd_top lsd_top_checker chk_i (.sys_clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .ladder_enable, .brightness_select, .lcd_scan_clock, .com_level, .seg_level);

// *** bench/test_lcd_segment_driver.sv ***
// Self-checking bench for the segment LCD driver.
`timescale 1ns/10ps
module test_lcd_segment_driver;
	import lsd_pkg::*;
	logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, slow_clk_in = 0, slow_on = 0;
	logic avs_waitrequest, ladder_enable, lcd_scan_clock;
	logic [ADDR_W-1:0] avs_address = 8'h00;
	logic [DATA_W-1:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'hf;
	logic [2:0] brightness_select;
	logic [NUM_COM*LV_W-1:0] com_level;
	logic [NUM_SEG*LV_W-1:0] seg_level;
	logic [7:0] mem [MEM_DEPTH];
	int n_errors = 0, checked = 0, dc, sc = 0, n;
	lsd_top DUT (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .slow_clk_in, .ladder_enable, .brightness_select, .lcd_scan_clock,
		.com_level, .seg_level);
	lsd_glass glass (.sys_clk, .com_level, .seg_level, .lcd_scan_clock, .dc);
	always #5 sys_clk = ~sys_clk;
	// The slow clock runs at an eighth of the system rate so slot lengths stay exact.
	always @(posedge sys_clk) begin
		sc <= sc + 1;
		if (slow_on && sc % 4 == 3)
			slow_clk_in <= ~slow_clk_in;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// A slave that never answers is caught by the watchdog, which counts it as a mismatch.
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge sys_clk);
	endtask : bus
	task automatic pulse();
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (lcd_scan_clock !== 1'b1 && n < 400);
		chk(lcd_scan_clock, 1);
	endtask : pulse
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic t_regs();
		bus(0, REG_CTRL, 0);
		chk(rd, 32'h0000_0000);
		bus(0, REG_DIV, 0);
		chk(rd, 32'h0000_0100);
		bus(1, REG_DIV, 2);
		for (int b = 0; b < 8; b++) begin
			bus(1, REG_CTRL, b * 2 + 1);
			@(negedge sys_clk);
			chk(brightness_select, b);
			chk(ladder_enable, 1);
			@(posedge sys_clk);
		end
		$display("registers done");
	endtask : t_regs
	task automatic t_mem();
		bus(1, REG_CTRL, 32'h0000_0031);
		for (int i = 0; i < MEM_DEPTH; i++) begin
			mem[i] = 8'h5a ^ 8'(i * 37);
			bus(1, 8'(4 * (32 + i)), mem[i]);
		end
		bus(0, 8'hcc, 0);
		chk(rd, mem[19]);
		bus(1, REG_CTRL, 32'h0000_0011);
		bus(1, 8'hb0, 32'h0000_00ff);
		bus(0, 8'hb0, 0);
		chk(rd, 0);
		bus(0, 8'hac, 0);
		chk(rd, mem[11]);
		$display("memory done");
	endtask : t_mem
	task automatic t_ladder();
		bus(1, REG_CTRL, 32'h0000_0030);
		repeat (10) begin
			pulse();
			chk(|{com_level, seg_level}, 0);
		end
		$display("ladder done");
	endtask : t_ladder
	task automatic t_scan(input logic [1:0] m);
		int last, sel, psel, d0, e;
		logic [2:0] b, off;
		bit pol, ppol, on;
		last = m == 0 ? 0 : m == 3 ? 7 : 3;
		b = m == 1 ? 3'h3 : m == 2 ? 3'h2 : 3'h1;
		off = m < 2 ? 3'h6 : m == 2 ? 3'h4 : 3'h3;
		bus(1, REG_CTRL, {m, 4'h1});
		repeat (60) @(posedge sys_clk);
		for (int j = 0; j <= 2 * last + 2; j++) begin
			pulse();
			if (j == 0)
				d0 = dc;
			sel = 0;
			for (int k = last; k >= 0; k--)
				if (com_level[k*3 +: 3] inside {3'h0, 3'h6})
					sel = k;
			pol = com_level[sel*3 +: 3] == 3'h0;
			if (j > 0) begin
				chk(sel, (psel + 1) % (last + 1));
				chk(pol, ppol ^ (sel == 0));
			end
			psel = sel;
			ppol = pol;
			for (int k = 0; k < 8; k++) begin
				e = k > last ? 0 : k == sel ? 6 : b;
				chk(com_level[k*3 +: 3], pol && k <= last ? 6 - e : e);
			end
			for (int k = 0; k < 24; k++) begin
				on = m == 3 ? k < 20 && mem[k][sel] : m == 0 ? !k[0] && mem[k/2][0] : mem[k/2][k%2*4+sel];
				e = on ? 0 : off;
				chk(seg_level[k*3 +: 3], pol ? 6 - e : e);
			end
		end
		chk(dc, d0);
		$display("scan mode %0d done", m);
	endtask : t_scan
	task automatic t_gap(input bit s, input int exp);
		slow_on <= s;
		bus(1, REG_CTRL, s ? 32'h0000_0071 : 32'h0000_0031);
		repeat (100) @(posedge sys_clk);
		pulse();
		pulse();
		chk(n, exp);
		$display("source %0d done", s);
	endtask : t_gap
	initial begin
		#400000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		t_regs();
		t_mem();
		t_ladder();
		for (int m = 0; m < 4; m++)
			t_scan(m[1:0]);
		t_gap(0, 3);
		t_gap(1, 24);
		conclude();
	end
endmodule : test_lcd_segment_driver
